// ===== shared/opa_pkg.sv
// Constants, carrier types and address decode for the optical power alarm threshold bank.
// Assumes a serial engine in front of this bank that already matched the device select
// address and hands over single byte reads and writes.
//
// Summary of operation
// R01 - Transmit low alarm sets when transmit power high byte is below its threshold.
// R02 - Receive high alarm sets when receive power high byte exceeds its threshold.
// R03 - Receive low alarm sets when receive power high byte is below its threshold.
// R04 - Threshold low bytes are stored but never take part in any comparison.
// R05 - Threshold is high and low byte; steps are 25.6 uW and 0.1 uW.
// R06 - Each sixteen bit threshold is an unsigned binary number.
// R07 - Thresholds are compared raw against raw measurement bytes, with no calibration.
// R08 - Low bytes of measured transmit and receive power always read as zero.
// R09 - Host should program every threshold low byte to zero.
// R10 - Transmit low threshold high byte at 0x1a, low byte at 0x1b.
// R11 - Alarms re-evaluate after every new measurement or threshold write.
package opa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial device select address of this bank
  localparam logic [6:0] OPA_DEV_ADDR = 7'h51;

  // Byte addresses of the threshold registers
  localparam logic [7:0] OPA_TX_LOW_MSB_ADDR = 8'h1a;
  localparam logic [7:0] OPA_TX_LOW_LSB_ADDR = 8'h1b;
  localparam logic [7:0] OPA_RX_HIGH_MSB_ADDR = 8'h20;
  localparam logic [7:0] OPA_RX_HIGH_LSB_ADDR = 8'h21;
  localparam logic [7:0] OPA_RX_LOW_MSB_ADDR = 8'h22;
  localparam logic [7:0] OPA_RX_LOW_LSB_ADDR = 8'h23;

  // Reset values, the fixed measurement low byte and the unmapped read byte
  localparam logic [7:0] OPA_THR_RESET = 8'h00;
  localparam logic [7:0] OPA_MEAS_RESET = 8'h00;
  localparam logic [7:0] OPA_MEAS_LSB_VAL = 8'h00;
  localparam logic [7:0] OPA_UNMAPPED_RD = 8'h00;

  // Weight of one step, in nanowatts
  localparam int OPA_MSB_STEP_NW = 25600;
  localparam int OPA_LSB_STEP_NW = 100;

  // Register slots in the bank; even slots are high bytes
  localparam int OPA_NUM_REGS = 6;
  localparam logic [2:0] OPA_IDX_TX_LOW_MSB = 3'h0;
  localparam logic [2:0] OPA_IDX_TX_LOW_LSB = 3'h1;
  localparam logic [2:0] OPA_IDX_RX_HIGH_MSB = 3'h2;
  localparam logic [2:0] OPA_IDX_RX_HIGH_LSB = 3'h3;
  localparam logic [2:0] OPA_IDX_RX_LOW_MSB = 3'h4;
  localparam logic [2:0] OPA_IDX_RX_LOW_LSB = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // One byte access from the serial engine
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } opa_reg_req_t;

  // A power value as high and low byte
  typedef struct packed {
    logic [7:0] msb;
    logic [7:0] lsb;
  } opa_meas_t;

  // Alarm flags, one per comparison
  typedef struct packed {
    logic rx_low;
    logic rx_high;
    logic tx_low;
  } opa_alarm_t;

  // Result of decoding a byte address
  typedef struct packed {
    logic hit;
    logic [2:0] idx;
  } opa_dec_t;

  ////////////////////////////////////////////////////////////////////////////
  // Byte address to register slot; used by the write path, read path and checks
  function automatic opa_dec_t opa_decode(input logic [7:0] addr);
    opa_dec_t d;
    d.hit = 1'b1;
    d.idx = OPA_IDX_TX_LOW_MSB;
    case (addr)
      OPA_TX_LOW_MSB_ADDR: d.idx = OPA_IDX_TX_LOW_MSB;
      OPA_TX_LOW_LSB_ADDR: d.idx = OPA_IDX_TX_LOW_LSB;
      OPA_RX_HIGH_MSB_ADDR: d.idx = OPA_IDX_RX_HIGH_MSB;
      OPA_RX_HIGH_LSB_ADDR: d.idx = OPA_IDX_RX_HIGH_LSB;
      OPA_RX_LOW_MSB_ADDR: d.idx = OPA_IDX_RX_LOW_MSB;
      OPA_RX_LOW_LSB_ADDR: d.idx = OPA_IDX_RX_LOW_LSB;
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction

endpackage

// ===== core/opa_cmp.sv
// Single unsigned magnitude comparator for one alarm.
// Assumes both operands are raw, uncalibrated high bytes held in registers upstream.
`timescale 1ns/1ps

module opa_cmp #(
  parameter int WIDTH = 8
) (
  // Operands
  input wire logic [WIDTH-1:0] meas,
  input wire logic [WIDTH-1:0] thr,
  // Direction: high selects the over-threshold test
  input wire logic above,
  // Result
  output logic hit
);

  ////////////////////////////////////////////////////////////////////////////
  // Plain unsigned compare; no scaling is applied to either side
  always_comb begin
    if (above) begin
      hit = meas > thr; // R02 R06 R07
    end else begin
      hit = meas < thr; // R01 R03 R06 R07
    end
  end

endmodule

// ===== core/opa_top.sv
// Optical power alarm threshold bank with its three alarm comparisons.
// Assumes a serial engine presents one byte access per cycle and a measurement
// path pulses meas_upd with fresh high bytes.
`timescale 1ns/1ps

module opa_top #(
  parameter int MEAS_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Byte access from the serial engine
  input wire opa_pkg::opa_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Fresh measurement from the converter
  input wire logic meas_upd,
  input wire logic [MEAS_W-1:0] tx_power_meas_msb,
  input wire logic [MEAS_W-1:0] rx_power_meas_msb,
  // Reported measurements and alarms
  output opa_pkg::opa_meas_t tx_meas,
  output opa_pkg::opa_meas_t rx_meas,
  output opa_pkg::opa_alarm_t alarm_flag
);
  import opa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] thr_q [OPA_NUM_REGS];
  logic [7:0] thr_d [OPA_NUM_REGS];
  logic [MEAS_W-1:0] tx_meas_q;
  logic [MEAS_W-1:0] tx_meas_d;
  logic [MEAS_W-1:0] rx_meas_q;
  logic [MEAS_W-1:0] rx_meas_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  opa_alarm_t alarm_q;
  opa_alarm_t alarm_d;
  opa_dec_t dec;
  logic [2:0] hit;
  logic [MEAS_W-1:0] cmp_meas [3];

  assign dec = opa_decode(reg_req.addr); // R10

  ////////////////////////////////////////////////////////////////////////////
  // Threshold bank: every byte is read/write, low bytes are kept for map layout only
  always_comb begin
    for (int i = 0; i < OPA_NUM_REGS; i++) begin
      thr_d[i] = thr_q[i];
    end
    if (reg_req.we && dec.hit) begin
      thr_d[dec.idx] = reg_req.wdata; // R05 R10
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < OPA_NUM_REGS; i++) begin
        thr_q[i] <= OPA_THR_RESET;
      end
    end else begin
      for (int i = 0; i < OPA_NUM_REGS; i++) begin
        thr_q[i] <= thr_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement holding registers; only the high byte is ever captured
  always_comb begin
    tx_meas_d = tx_meas_q;
    rx_meas_d = rx_meas_q;
    if (meas_upd) begin
      tx_meas_d = tx_power_meas_msb;
      rx_meas_d = rx_power_meas_msb;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_meas_q <= MEAS_W'(OPA_MEAS_RESET);
      rx_meas_q <= MEAS_W'(OPA_MEAS_RESET);
    end else begin
      tx_meas_q <= tx_meas_d;
      rx_meas_q <= rx_meas_d;
    end
  end

  // Low bytes are constant zero so the host never sees meaningless bits
  assign tx_meas.msb = 8'(tx_meas_q);
  assign tx_meas.lsb = OPA_MEAS_LSB_VAL; // R08
  assign rx_meas.msb = 8'(rx_meas_q);
  assign rx_meas.lsb = OPA_MEAS_LSB_VAL; // R08

  ////////////////////////////////////////////////////////////////////////////
  // Comparators: only the even (high byte) slots feed them
  assign cmp_meas[0] = tx_meas_q;
  assign cmp_meas[1] = rx_meas_q;
  assign cmp_meas[2] = rx_meas_q;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cmp
      opa_cmp #(
        .WIDTH(MEAS_W)
      ) u_cmp (
        .meas(cmp_meas[g]),
        .thr(MEAS_W'(thr_q[2*g])), // R04
        .above(g == 1),
        .hit(hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Alarm flags follow the comparators every cycle, so a new measurement or a
  // new threshold shows one cycle after it lands in its register
  always_comb begin
    alarm_d.tx_low = hit[0]; // R01
    alarm_d.rx_high = hit[1]; // R02
    alarm_d.rx_low = hit[2]; // R03
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_d; // R11
    end
  end

  assign alarm_flag = alarm_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the request; unmapped bytes read zero
  always_comb begin
    rvalid_d = reg_req.re;
    rdata_d = rdata_q;
    if (reg_req.re) begin
      rdata_d = dec.hit ? thr_q[dec.idx] : OPA_UNMAPPED_RD;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_lsb_write;
    reg_req.we && dec.hit && dec.idx[0] && !meas_upd;
  endsequence

  sequence s_new_meas;
    meas_upd;
  endsequence

  sequence s_map_write;
    reg_req.we && dec.hit;
  endsequence

  a_tx_low_alarm: assert property ( // R01
    alarm_flag.tx_low == $past(tx_meas_q < thr_q[OPA_IDX_TX_LOW_MSB]))
    else $error("tx low alarm does not match compare");

  a_rx_high_alarm: assert property ( // R02
    alarm_flag.rx_high == $past(rx_meas_q > thr_q[OPA_IDX_RX_HIGH_MSB]))
    else $error("rx high alarm does not match compare");

  a_rx_low_alarm: assert property ( // R03
    alarm_flag.rx_low == $past(rx_meas_q < thr_q[OPA_IDX_RX_LOW_MSB]))
    else $error("rx low alarm does not match compare");

  a_lsb_no_effect: assert property ( // R04
    s_lsb_write |=> ##1 $stable(alarm_flag))
    else $error("low byte write changed an alarm");

  a_thr_write_store: assert property ( // R05
    s_map_write |=> thr_q[$past(dec.idx)] == $past(reg_req.wdata))
    else $error("threshold byte not stored");

  a_meas_lsb_zero: assert property ( // R08
    tx_meas.lsb == 8'h00 && rx_meas.lsb == 8'h00)
    else $error("measurement low byte not zero");

  a_meas_reeval: assert property ( // R11
    s_new_meas |=> ##1 alarm_flag.rx_high == ($past(rx_power_meas_msb, 2) >
      thr_q[OPA_IDX_RX_HIGH_MSB]) || $past(reg_req.we))
    else $error("alarm not updated after new measurement");

  a_tx_thr_addr: assert property ( // R10
    reg_req.we && reg_req.addr == OPA_TX_LOW_MSB_ADDR |=>
      thr_q[OPA_IDX_TX_LOW_MSB] == $past(reg_req.wdata))
    else $error("tx low high byte not at its address");

  a_read_answer: assert property ( // R10
    reg_req.re && !dec.hit |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Register port and measurement checks beyond the map itself
  sequence s_map_read;
    reg_req.re && dec.hit;
  endsequence

  sequence s_tx_thr_write;
    reg_req.we && reg_req.addr == OPA_TX_LOW_MSB_ADDR && !meas_upd;
  endsequence

  sequence s_rx_thr_write;
    reg_req.we && reg_req.addr == OPA_RX_HIGH_MSB_ADDR && !meas_upd;
  endsequence

  // Nothing that could move an alarm arrives in this cycle
  sequence s_quiet;
    !reg_req.we && !meas_upd;
  endsequence

  // A mapped read returns the byte held before the edge, so a write in the
  // same cycle is only seen by the next read
  a_read_mapped: assert property ( // R10
    s_map_read |=> reg_rvalid && reg_rdata == $past(thr_q[dec.idx]))
    else $error("mapped read returned wrong byte");

  // Valid pulses once per read strobe and never on its own
  a_rvalid_pulse: assert property ( // R10
    reg_rvalid == $past(reg_req.re))
    else $error("read valid does not follow read strobe");

  // Read data holds between reads, so a slow consumer may take it late
  a_rdata_hold: assert property ( // R10
    !reg_req.re |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // Each slot changes only under a write aimed at it; stray addresses land nowhere
  for (genvar s = 0; s < OPA_NUM_REGS; s++) begin : g_slot_chk
    a_slot_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
      !(reg_req.we && dec.hit && dec.idx == 3'(s)) |=> $stable(thr_q[s]))
      else $error("threshold byte changed without a write");
  end

  // A fresh measurement shows one cycle after its strobe
  a_meas_capture: assert property ( // R11
    s_new_meas |=> tx_meas.msb == $past(tx_power_meas_msb) &&
      rx_meas.msb == $past(rx_power_meas_msb))
    else $error("measurement not captured");

  // Between strobes the held measurement must not drift
  a_meas_hold: assert property ( // R11
    !meas_upd |=> $stable(tx_meas) && $stable(rx_meas))
    else $error("measurement moved without a strobe");

  // The two low alarms follow a new measurement two cycles on, unless a
  // threshold write landed in between and moved the reference
  a_tx_reeval: assert property ( // R11
    s_new_meas |=> ##1 alarm_flag.tx_low == ($past(tx_power_meas_msb, 2) <
      thr_q[OPA_IDX_TX_LOW_MSB]) || $past(reg_req.we))
    else $error("tx low alarm not updated after new measurement");

  a_rx_low_reeval: assert property ( // R11
    s_new_meas |=> ##1 alarm_flag.rx_low == ($past(rx_power_meas_msb, 2) <
      thr_q[OPA_IDX_RX_LOW_MSB]) || $past(reg_req.we))
    else $error("rx low alarm not updated after new measurement");

  // A new high byte threshold reaches its alarm two cycles after the write,
  // with the held measurement unchanged
  a_tx_thr_reeval: assert property ( // R11
    s_tx_thr_write ##1 s_quiet |=> alarm_flag.tx_low ==
      (tx_meas_q < $past(reg_req.wdata, 2)))
    else $error("tx low alarm not updated after threshold write");

  a_rx_thr_reeval: assert property ( // R11
    s_rx_thr_write ##1 s_quiet |=> alarm_flag.rx_high ==
      (rx_meas_q > $past(reg_req.wdata, 2)))
    else $error("rx high alarm not updated after threshold write");

endmodule

// ===== test/opa_host.sv
// Host model of the serial register engine: issues single byte reads and writes.
// Assumes the bank takes a request at a rising edge and answers a read one cycle later.
`timescale 1ns/1ps

module opa_host (
  // Clock
  input wire logic ref_clk,
  // Byte access toward the bank
  output opa_pkg::opa_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  import opa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Idle at time zero; fields shown while idle are junk on purpose
  initial reg_req = '{we: 1'b0, re: 1'b0, addr: 8'hff, wdata: 8'ha5};

  // One byte write; released fields are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One byte read; waits a bounded time for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk);
    reg_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h3c};
    @(posedge ref_clk);
    reg_req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: 8'hc3};
    d = 8'hxx;
    n = 0;
    while (n < 4) begin
      // Valid and data are taken at the edge that samples them, before they move
      @(posedge ref_clk);
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        n = 4;
      end
      n++;
    end
  endtask

  // Usual host habit: low bytes carry no weight in compares, so keep them zero
  task automatic zero_lows();
    wr(8'h1b, 8'h00);
    wr(8'h21, 8'h00);
    wr(8'h23, 8'h00);
  endtask
endmodule

// ===== test/optical_power_alarm_thresholds_test.sv
// Self-checking bench for the optical power alarm threshold bank.
// Assumes the host model in opa_host drives the byte access port.
`timescale 1ns/1ps

module optical_power_alarm_thresholds_test;
  import opa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset and design signals
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic meas_upd = 1'b0;
  logic [7:0] tx_power_meas_msb = 8'h00;
  logic [7:0] rx_power_meas_msb = 8'h00;
  opa_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  opa_meas_t tx_meas;
  opa_meas_t rx_meas;
  opa_alarm_t alarm_flag;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] rv;
  // Map written out by hand so the decoder is checked independently
  logic [7:0] addrs [6] = '{8'h1a, 8'h1b, 8'h20, 8'h21, 8'h22, 8'h23};

  always #12.5 ref_clk = ~ref_clk;

  opa_top opa_top_inst (
    .ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .meas_upd(meas_upd), .tx_power_meas_msb(tx_power_meas_msb),
    .rx_power_meas_msb(rx_power_meas_msb), .tx_meas(tx_meas), .rx_meas(rx_meas),
    .alarm_flag(alarm_flag)
  );

  opa_host opa_host_inst (
    .ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard; the whole run needs fewer than two hundred cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  // Let writes and measurements reach the alarm levels
  task automatic wt();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic meas(input logic [7:0] t, input logic [7:0] r);
    @(posedge ref_clk);
    meas_upd <= 1'b1;
    tx_power_meas_msb <= t;
    rx_power_meas_msb <= r;
    @(posedge ref_clk);
    meas_upd <= 1'b0;
    wt();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset, then every register and an unmapped slot read back as zero
  task automatic t_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      opa_host_inst.rd(addrs[i], rv);
      chk({8'h00, rv}, 16'h0000);
    end
    opa_host_inst.rd(8'h1c, rv);
    chk({8'h00, rv}, 16'h0000);
    chk({tx_meas.lsb, rx_meas.lsb}, 16'h0000);
    chk({13'h0, alarm_flag}, 16'h0000);
  endtask

  // Distinct bytes in all six slots; an unmapped write must not land anywhere
  task automatic t_map();
    for (int i = 0; i < 6; i++)
      opa_host_inst.wr(addrs[i], 8'h3c + 8'(i * 17));
    opa_host_inst.wr(8'h1c, 8'hee);
    for (int i = 0; i < 6; i++) begin
      opa_host_inst.rd(addrs[i], rv);
      chk({8'h00, rv}, {8'h00, 8'h3c + 8'(i * 17)});
    end
    opa_host_inst.rd(8'h1c, rv);
    chk({8'h00, rv}, 16'h0000);
  endtask

  // Boundaries of all three compares with low bytes full of ones
  task automatic t_cmp();
    logic [7:0] tv [6];
    logic [7:0] rx [6];
    logic [2:0] e;
    tv = '{8'h3f, 8'h40, 8'h41, 8'h00, 8'hff, 8'h40};
    rx = '{8'h1f, 8'h20, 8'h21, 8'h80, 8'h81, 8'hff};
    opa_host_inst.wr(8'h1a, 8'h40);
    opa_host_inst.wr(8'h1b, 8'hff);
    opa_host_inst.wr(8'h20, 8'h80);
    opa_host_inst.wr(8'h21, 8'hff);
    opa_host_inst.wr(8'h22, 8'h20);
    opa_host_inst.wr(8'h23, 8'hff);
    for (int i = 0; i < 6; i++) begin
      meas(tv[i], rx[i]);
      e = {rx[i] < 8'h20, rx[i] > 8'h80, tv[i] < 8'h40};
      chk({13'h0, alarm_flag}, {13'h0, e});
      chk(tx_meas, {tv[i], 8'h00});
      chk(rx_meas, {rx[i], 8'h00});
    end
  endtask

  // Threshold writes alone must move the alarms, with no new measurement
  task automatic t_reeval();
    meas(8'h40, 8'h50);
    chk({13'h0, alarm_flag}, 16'h0000);
    opa_host_inst.wr(8'h1a, 8'h41);
    wt();
    chk({13'h0, alarm_flag}, 16'h0001);
    opa_host_inst.wr(8'h20, 8'h4f);
    opa_host_inst.wr(8'h22, 8'h51);
    wt();
    chk({13'h0, alarm_flag}, 16'h0007);
    opa_host_inst.zero_lows();
    wt();
    chk({13'h0, alarm_flag}, 16'h0007);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; the second reset lands in mid-run with thresholds loaded
  initial begin
    t_reset();
    t_map();
    t_cmp();
    t_reeval();
    t_reset();
    stop_test();
  end
endmodule
